// file: testbench.sv
// Purpose: self-checking bench of the type-c port control block
// Assumes: debounce counts shortened to 8 and 4 cycles
// Notes: expected values are worked out here from the register map
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    tpc_pkg::tpc_bus_s bus_in = '0;
    tpc_pkg::tpc_cc_e cc1, cc2;
    tpc_pkg::tpc_cc_e rp_adv = tpc_pkg::CC_RP_DEF;
    logic cable_pw = 1'b1;
    logic fwd_g = 1'b0;
    logic rev_g = 1'b0;
    logic [1:0] plug = 2'b00;
    logic [2:0] pins;
    logic [7:0] bus_rdata, d;
    logic [1:0] rp_en, rd_en, rp_lvl, vc_cc, lim;
    logic flip, dbg, irq_oe, src_en, pa_en, pb_en;
    int err_total = 0;
    int total_checks = 0;
    tpc_port_ctrl #(.ATTACH_DB_CYC(8), .DETACH_DB_CYC(4)) i_tpc_port_ctrl (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_in(bus_in), .bus_rdata(bus_rdata),
        .cc1_class_in(cc1), .cc2_class_in(cc2), .cable_power_in(cable_pw),
        .forward_overcurrent_guard(fwd_g), .reverse_current_guard(rev_g), .path_pin_in(pins),
        .cc_rp_en(rp_en), .cc_rd_en(rd_en), .rp_level_out(rp_lvl), .vconn_to_cc(vc_cc),
        .fwd_limit_out(lim), .plug_flip_out(flip), .debug_accessory_out(dbg),
        .irq_n_oe(irq_oe), .source_path_enable(src_en), .power_path_a_enable(pa_en),
        .power_path_b_enable(pb_en));
    tpc_far_end i_tpc_far_end (.cc_rp_en(rp_en), .plug(plug), .rp_adv(rp_adv),
        .path_oe({pb_en, pa_en, src_en}), .cc1_class(cc1), .cc2_class(cc2), .path_pin(pins));
    initial forever #50 clk_sys = ~clk_sys;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_in <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_in <= '0;
        #1;
        chk(bus_rdata, exp);
    endtask
    // plug change and a bounded wait for the event it raises
    task automatic connect(input logic [1:0] p);
        @(posedge clk_sys);
        plug <= p;
        for (int i = 0; i < 100 && irq_oe !== 1'b1; i++) @(posedge clk_sys);
        #1;
        chk({7'h0, irq_oe}, 8'h01);
    endtask
    task automatic tdone(input int n);
        $display("test %0d done", n);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        finish_test;
    end
    initial begin
        void'($urandom(55298));
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        tick(1);
        chk({3'h0, vc_cc, src_en, pa_en, pb_en}, 8'h00);
        chk({6'h0, flip, dbg}, 8'h02);
        chk({6'h0, rd_en}, 8'h03);
        rd(tpc_pkg::ADDR_MASK, 8'h0F);
        rd(8'h3C, 8'h00);
        tdone(1);
        wr(tpc_pkg::ADDR_CONFIG, 8'h15);
        tick(2);
        chk({2'h0, rp_en, rd_en, rp_lvl}, 8'h32);
        chk({7'h0, flip}, 8'h00);
        tdone(2);
        @(posedge clk_sys);
        plug <= 2'b10;
        repeat (4) @(posedge clk_sys);
        plug <= 2'b00;
        tick(20);
        chk({7'h0, irq_oe}, 8'h00);
        connect(2'b10);
        rd(tpc_pkg::ADDR_EVENT, 8'h01);
        chk({7'h0, flip}, 8'h01);
        rd(tpc_pkg::ADDR_STATUS, 8'h86);
        wr(tpc_pkg::ADDR_MASK, 8'h0E);
        tick(2);
        chk({7'h0, irq_oe}, 8'h00);
        wr(tpc_pkg::ADDR_MASK, 8'h0F);
        wr(tpc_pkg::ADDR_EVENT, 8'h01);
        tick(3);
        chk({7'h0, irq_oe}, 8'h00);
        tdone(3);
        d = 8'($urandom_range(3, 0));
        wr(tpc_pkg::ADDR_VCONN, {5'h0, d[1:0], 1'b1});
        tick(2);
        chk({4'h0, lim, vc_cc}, {4'h0, d[1:0], 2'b01});
        for (int g = 0; g < 2; g++) begin
            @(posedge clk_sys);
            fwd_g <= (g == 0);
            rev_g <= (g == 1);
            tick(6);
            chk({6'h0, vc_cc}, 8'h00);
            @(posedge clk_sys);
            fwd_g <= 1'b0;
            rev_g <= 1'b0;
            wr(tpc_pkg::ADDR_VCONN, {5'h0, d[1:0], 1'b1});
            tick(4);
            chk({6'h0, vc_cc}, 8'h00);
            rd(tpc_pkg::ADDR_EVENT, 8'h04 << g);
            wr(tpc_pkg::ADDR_EVENT, 8'hFF);
            wr(tpc_pkg::ADDR_VCONN, {5'h0, d[1:0], 1'b1});
            tick(2);
            chk({6'h0, vc_cc}, 8'h01);
        end
        @(posedge clk_sys);
        cable_pw <= 1'b0;
        fwd_g <= 1'b1;
        tick(6);
        chk({6'h0, vc_cc}, 8'h01);
        rd(tpc_pkg::ADDR_STATUS, 8'h07);
        @(posedge clk_sys);
        fwd_g <= 1'b0;
        tdone(4);
        connect(2'b00);
        rd(tpc_pkg::ADDR_EVENT, 8'h02);
        chk({6'h0, vc_cc}, 8'h00);
        wr(tpc_pkg::ADDR_VCONN, 8'h00);
        wr(tpc_pkg::ADDR_EVENT, 8'hFF);
        wr(tpc_pkg::ADDR_CONFIG, 8'h10);
        rp_adv <= tpc_pkg::CC_RP_15;
        connect(2'b01);
        chk({4'h0, rp_en, rd_en}, 8'h03);
        rd(tpc_pkg::ADDR_STATUS, 8'h22);
        wr(tpc_pkg::ADDR_VCONN, 8'h01);
        tick(2);
        chk({6'h0, vc_cc}, 8'h02);
        wr(tpc_pkg::ADDR_VCONN, 8'h00);
        wr(tpc_pkg::ADDR_EVENT, 8'hFF);
        tick(3);
        connect(2'b00);
        wr(tpc_pkg::ADDR_EVENT, 8'hFF);
        tdone(5);
        wr(tpc_pkg::ADDR_CONFIG, 8'h11);
        connect(2'b11);
        chk({7'h0, dbg}, 8'h01);
        wr(tpc_pkg::ADDR_EVENT, 8'hFF);
        tick(3);
        connect(2'b00);
        chk({7'h0, dbg}, 8'h00);
        wr(tpc_pkg::ADDR_EVENT, 8'hFF);
        tdone(6);
        wr(tpc_pkg::ADDR_CONFIG, 8'h19);
        wr(tpc_pkg::ADDR_MANUAL, 8'h07);
        tick(3);
        rd(tpc_pkg::ADDR_EVENT, 8'h01);
        chk({7'h0, flip}, 8'h01);
        chk({7'h0, dbg}, 8'h01);
        wr(tpc_pkg::ADDR_MANUAL, 8'h00);
        tick(3);
        rd(tpc_pkg::ADDR_EVENT, 8'h03);
        tdone(7);
        repeat (6) begin
            d = 8'($urandom_range(31, 0));
            wr(tpc_pkg::ADDR_PATH, d);
            tick(6);
            chk({5'h0, pb_en, pa_en, src_en}, {5'h0, d[2:0]});
            rd(tpc_pkg::ADDR_PATH, d);
            rd(tpc_pkg::ADDR_PATH_STAT, {5'h0, ~d[2:0]});
        end
        tdone(8);
        finish_test;
    end
endmodule

// file: tpc_far_end.sv
// Purpose: far end of the cc lines and of the power path pins
// Assumes: plug 0 none, 1 on cc1, 2 on cc2, 3 debug accessory on both
// Notes: path pins are pulled up, a driven enable pulls its pin low
`timescale 1ns/1ps
module tpc_far_end (
    input wire logic [1:0] cc_rp_en,
    input wire logic [1:0] plug,
    input wire tpc_pkg::tpc_cc_e rp_adv,
    input wire logic [2:0] path_oe,
    output tpc_pkg::tpc_cc_e cc1_class,
    output tpc_pkg::tpc_cc_e cc2_class,
    output logic [2:0] path_pin
);
    tpc_pkg::tpc_cc_e seen;
    // a sink answers rp with rd, a source answers rd with its advertised level
    assign seen = (cc_rp_en != 2'b00) ? tpc_pkg::CC_RD : rp_adv;
    assign cc1_class = plug[0] ? seen : tpc_pkg::CC_OPEN;
    assign cc2_class = plug[1] ? seen : tpc_pkg::CC_OPEN;
    assign path_pin = ~path_oe;
endmodule

// file: tpc_pkg.sv
// Purpose: shared constants and types of the type-c port control block
// Assumes: 8-bit register port, 10 MHz core clock
// Notes: cc line classes come from the analog front end comparators
package tpc_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int ATTACH_DB_MS = 100;
    localparam int DETACH_DB_MS = 10;
    localparam int ATTACH_DB_CYC = ATTACH_DB_MS * (CLK_HZ / 1000);
    localparam int DETACH_DB_CYC = DETACH_DB_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 20;

    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_MANUAL = 8'h01;
    localparam logic [7:0] ADDR_EVENT = 8'h02;
    localparam logic [7:0] ADDR_MASK = 8'h03;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_VCONN = 8'h05;
    localparam logic [7:0] ADDR_PATH = 8'h06;
    localparam logic [7:0] ADDR_PATH_STAT = 8'h07;

    // config fields
    localparam int CFG_ROLE = 0;
    localparam int CFG_RP_LSB = 1;
    localparam int CFG_MANUAL = 3;
    localparam int CFG_INIT = 4;
    // manual fields
    localparam int MAN_ATTACH = 0;
    localparam int MAN_FLIP = 1;
    localparam int MAN_DEBUG = 2;
    // event fields
    localparam int EVT_ATTACH = 0;
    localparam int EVT_DETACH = 1;
    localparam int EVT_FWD = 2;
    localparam int EVT_REV = 3;
    // vconn fields
    localparam int VC_EN = 0;
    localparam int VC_LIM_LSB = 1;
    // path fields
    localparam int PATH_A_USE = 3;
    localparam int PATH_B_USE = 4;

    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] MANUAL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h0F;
    localparam logic [7:0] VCONN_RST = 8'h00;
    localparam logic [7:0] PATH_RST = 8'h00;

    typedef enum logic [2:0] {
        CC_OPEN = 3'h0,
        CC_RA = 3'h1,
        CC_RD = 3'h2,
        CC_RP_DEF = 3'h3,
        CC_RP_15 = 3'h4,
        CC_RP_30 = 3'h5
    } tpc_cc_e;

    typedef enum logic [3:0] {
        ST_UNATT = 4'h1,
        ST_ATT_WAIT = 4'h2,
        ST_ATT = 4'h4,
        ST_DET_WAIT = 4'h8
    } tpc_conn_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tpc_bus_s;
endpackage

// file: tpc_port_ctrl.sv
// Purpose: type-c port control: terminations, attach, orientation, vconn, power paths
// Assumes: cc classes, trips and pin levels arrive asynchronously and are synchronised
// Notes: open-drain pins are driven as output enables, high pulls the pin low
//
// Overview of operation
// R1 - Apply Rp or Rd on both CC lines according to the configured role.
// R2 - Detect attach and detach on CC and report each as an event.
// R3 - Debounce attach and detach so only stable changes make events.
// R4 - As source, advertise the configured current level on CC.
// R5 - As sink, capture the remote advertised current level into status.
// R6 - Orientation comes from which CC line carries the connection.
// R7 - Orientation pin low for CC1, high for CC2 after initialisation.
// R8 - Orientation pin inverted from reset until firmware sets the init bit.
// R9 - Detect a debug accessory and show it on its own pin.
// R10 - Debug accessory pin low after reset until one is detected.
// R11 - Port events update event and status registers and raise the interrupt.
// R12 - Interrupt is active-low open-drain level, held while unmasked events pend.
// R13 - VCONN goes to the CC line opposite the communication line.
// R14 - VCONN switch on or off by register; off means high impedance.
// R15 - Forward trip level of the VCONN switch is register settable.
// R16 - Forward overcurrent opens the switch and raises an event.
// R17 - Reverse current opens the switch and raises an event.
// R18 - After a trip the switch stays open until event read and re-enable; the lock clears on an event register read.
// R19 - Current protection acts only while cable power is flagged valid.
// R20 - Three open-drain power path enables set and cleared by register.
// R21 - Each power path pin level is sampled into a status register.
// R22 - Each general path has a selectable source or sink use.
// R23 - Attach, termination and orientation run autonomous or under manual command; terminations follow the role bit in both modes.
// R24 - After reset all power paths and VCONN stay off until enabled.
`timescale 1ns/1ps
module tpc_port_ctrl #(
    parameter int ATTACH_DB_CYC = tpc_pkg::ATTACH_DB_CYC,
    parameter int DETACH_DB_CYC = tpc_pkg::DETACH_DB_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire tpc_pkg::tpc_bus_s bus_in,
    output logic [7:0] bus_rdata,
    input wire logic [2:0] cc1_class_in,
    input wire logic [2:0] cc2_class_in,
    input wire logic cable_power_in,
    input wire logic forward_overcurrent_guard,
    input wire logic reverse_current_guard,
    input wire logic [2:0] path_pin_in,
    output logic [1:0] cc_rp_en,
    output logic [1:0] cc_rd_en,
    output logic [1:0] rp_level_out,
    output logic [1:0] vconn_to_cc,
    output logic [1:0] fwd_limit_out,
    output logic plug_flip_out,
    output logic debug_accessory_out,
    output logic irq_n_oe,
    output logic source_path_enable,
    output logic power_path_a_enable,
    output logic power_path_b_enable
);
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] man;
        logic [3:0] evt;
        logic [3:0] mask;
        logic [2:0] vctl;
        logic [4:0] pctl;
        logic [7:0] rdata;
        tpc_pkg::tpc_conn_e conn;
        logic [tpc_pkg::CNT_W-1:0] cnt;
        logic flip;
        logic dbg;
        logic [1:0] remote;
        logic trip_lock;
        logic [12:0] s1;
        logic [12:0] s2;
        logic [1:0] rp_en;
        logic [1:0] rd_en;
        logic [1:0] vc_to;
        logic flip_pin;
        logic dbg_pin;
        logic irq;
        logic [2:0] path;
    } tpc_state_s;

    tpc_state_s st_reg;
    tpc_state_s st_next;

    // true when the class is any Rp advertisement
    function automatic logic is_rp(input logic [2:0] c);
        return c == tpc_pkg::CC_RP_DEF || c == tpc_pkg::CC_RP_15 || c == tpc_pkg::CC_RP_30;
    endfunction

    // maps an Rp class to a two-bit current level
    function automatic logic [1:0] rp_code(input logic [2:0] c);
        case (c)
            tpc_pkg::CC_RP_DEF: return 2'h1;
            tpc_pkg::CC_RP_15: return 2'h2;
            tpc_pkg::CC_RP_30: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction

    logic [2:0] cc1;
    logic [2:0] cc2;
    logic pwr_ok;
    logic fwd;
    logic rev;
    logic [2:0] pins;
    logic role_src;
    logic hit1;
    logic hit2;
    logic seen;
    logic auto_mode;
    logic att_now;
    logic fwd_trip;
    logic rev_trip;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic wr_hit;
    logic rd_hit;

    assign cc1 = st_reg.s2[2:0];
    assign cc2 = st_reg.s2[5:3];
    assign pwr_ok = st_reg.s2[6];
    assign fwd = st_reg.s2[7];
    assign rev = st_reg.s2[8];
    assign pins = st_reg.s2[11:9];
    assign role_src = st_reg.cfg[tpc_pkg::CFG_ROLE];
    assign auto_mode = !st_reg.cfg[tpc_pkg::CFG_MANUAL];
    assign wr_hit = bus_in.wr;
    assign rd_hit = bus_in.rd;

    always_comb begin
        st_next = st_reg;
        // second stage of every synchroniser is read, the first stage only feeds it
        st_next.s1 = {1'b0, path_pin_in, reverse_current_guard, forward_overcurrent_guard,
                      cable_power_in, cc2_class_in, cc1_class_in};
        st_next.s2 = st_reg.s1;

        // a partner on a line: Rd seen as source, Rp seen as sink
        hit1 = role_src ? (cc1 == tpc_pkg::CC_RD) : is_rp(cc1); // R2
        hit2 = role_src ? (cc2 == tpc_pkg::CC_RD) : is_rp(cc2); // R2
        seen = hit1 || hit2;
        att_now = st_reg.conn == tpc_pkg::ST_ATT || st_reg.conn == tpc_pkg::ST_DET_WAIT;
        ev_set = 4'h0;

        // connection tracking with debounce
        if (auto_mode) begin // R23
            case (st_reg.conn)
                tpc_pkg::ST_UNATT: begin
                    st_next.cnt = '0;
                    if (seen) begin
                        st_next.conn = tpc_pkg::ST_ATT_WAIT;
                    end
                end
                tpc_pkg::ST_ATT_WAIT: begin
                    if (!seen) begin
                        st_next.conn = tpc_pkg::ST_UNATT; // R3
                    end else if (st_reg.cnt == tpc_pkg::CNT_W'(ATTACH_DB_CYC - 1)) begin
                        st_next.conn = tpc_pkg::ST_ATT; // R3
                        st_next.cnt = '0;
                        st_next.flip = !hit1 && hit2; // R6
                        st_next.dbg = hit1 && hit2; // R9
                        ev_set[tpc_pkg::EVT_ATTACH] = 1'b1; // R2
                    end else begin
                        st_next.cnt = st_reg.cnt + 1'b1;
                    end
                end
                tpc_pkg::ST_ATT: begin
                    st_next.cnt = '0;
                    if (!seen) begin
                        st_next.conn = tpc_pkg::ST_DET_WAIT;
                    end
                end
                tpc_pkg::ST_DET_WAIT: begin
                    if (seen) begin
                        st_next.conn = tpc_pkg::ST_ATT; // R3
                    end else if (st_reg.cnt == tpc_pkg::CNT_W'(DETACH_DB_CYC - 1)) begin
                        st_next.conn = tpc_pkg::ST_UNATT; // R3
                        st_next.cnt = '0;
                        st_next.flip = 1'b0;
                        st_next.dbg = 1'b0; // R10
                        ev_set[tpc_pkg::EVT_DETACH] = 1'b1; // R2
                    end else begin
                        st_next.cnt = st_reg.cnt + 1'b1;
                    end
                end
                default: begin
                    st_next.conn = tpc_pkg::ST_UNATT;
                    st_next.cnt = '0;
                end
            endcase
        end else begin
            // firmware drives the connection directly
            st_next.cnt = '0;
            st_next.flip = st_reg.man[tpc_pkg::MAN_FLIP]; // R23
            st_next.dbg = st_reg.man[tpc_pkg::MAN_DEBUG] && st_reg.man[tpc_pkg::MAN_ATTACH];
            if (st_reg.man[tpc_pkg::MAN_ATTACH] && !att_now) begin
                st_next.conn = tpc_pkg::ST_ATT;
                ev_set[tpc_pkg::EVT_ATTACH] = 1'b1; // R23
            end else if (!st_reg.man[tpc_pkg::MAN_ATTACH] && att_now) begin
                st_next.conn = tpc_pkg::ST_UNATT;
                ev_set[tpc_pkg::EVT_DETACH] = 1'b1; // R23
            end else if (!att_now) begin
                st_next.conn = tpc_pkg::ST_UNATT;
            end
        end

        // remote advertisement on the active line while sinking
        if (!role_src && att_now) begin
            st_next.remote = st_reg.flip ? rp_code(cc2) : rp_code(cc1); // R5
        end else begin
            st_next.remote = 2'h0;
        end

        // vconn current protection, armed only with valid cable power
        fwd_trip = st_reg.vctl[tpc_pkg::VC_EN] && pwr_ok && fwd; // R19 R16
        rev_trip = st_reg.vctl[tpc_pkg::VC_EN] && pwr_ok && rev; // R19 R17
        if (fwd_trip || rev_trip) begin
            st_next.vctl[tpc_pkg::VC_EN] = 1'b0; // R16 R17
            st_next.trip_lock = 1'b1; // R18
        end
        ev_set[tpc_pkg::EVT_FWD] = fwd_trip; // R16
        ev_set[tpc_pkg::EVT_REV] = rev_trip; // R17

        // register writes
        ev_clr = 4'h0;
        if (wr_hit) begin
            case (bus_in.addr)
                tpc_pkg::ADDR_CONFIG: st_next.cfg = {3'h0, bus_in.wdata[4:0]};
                tpc_pkg::ADDR_MANUAL: st_next.man = {5'h0, bus_in.wdata[2:0]};
                tpc_pkg::ADDR_EVENT: ev_clr = bus_in.wdata[3:0];
                tpc_pkg::ADDR_MASK: st_next.mask = bus_in.wdata[3:0];
                tpc_pkg::ADDR_VCONN: begin
                    st_next.vctl[2:1] = bus_in.wdata[2:1]; // R15
                    // enable refused while a trip is unread or a trip is happening
                    if (!st_reg.trip_lock && !fwd_trip && !rev_trip) begin // R18
                        st_next.vctl[tpc_pkg::VC_EN] = bus_in.wdata[0]; // R14
                    end
                end
                tpc_pkg::ADDR_PATH: st_next.pctl = bus_in.wdata[4:0]; // R20 R22
                default: begin
                end
            endcase
        end
        // set wins over clear
        st_next.evt = (st_reg.evt & ~ev_clr) | ev_set; // R11

        // register reads, data in the next cycle only
        st_next.rdata = 8'h00;
        if (rd_hit) begin
            case (bus_in.addr)
                tpc_pkg::ADDR_CONFIG: st_next.rdata = st_reg.cfg;
                tpc_pkg::ADDR_MANUAL: st_next.rdata = st_reg.man;
                tpc_pkg::ADDR_EVENT: begin
                    st_next.rdata = {4'h0, st_reg.evt};
                    if (!fwd_trip && !rev_trip) begin
                        st_next.trip_lock = 1'b0; // R18
                    end
                end
                tpc_pkg::ADDR_MASK: st_next.rdata = {4'h0, st_reg.mask};
                tpc_pkg::ADDR_STATUS: st_next.rdata = {pwr_ok, st_reg.trip_lock,
                    st_reg.remote, st_reg.dbg, st_reg.flip, att_now, st_reg.vctl[0]}; // R11 R5
                tpc_pkg::ADDR_VCONN: st_next.rdata = {5'h0, st_reg.vctl};
                tpc_pkg::ADDR_PATH: st_next.rdata = {3'h0, st_reg.pctl};
                tpc_pkg::ADDR_PATH_STAT: st_next.rdata = {5'h0, pins}; // R21
                default: st_next.rdata = 8'h00;
            endcase
        end

        // terminations
        st_next.rp_en = role_src ? 2'b11 : 2'b00; // R1 R4
        st_next.rd_en = role_src ? 2'b00 : 2'b11; // R1

        // vconn to the line opposite the communication line
        if (st_reg.vctl[tpc_pkg::VC_EN] && att_now && !st_reg.dbg) begin // R14
            st_next.vc_to = st_reg.flip ? 2'b01 : 2'b10; // R13
        end else begin
            st_next.vc_to = 2'b00; // R14 R24
        end

        st_next.flip_pin = st_reg.flip ^ !st_reg.cfg[tpc_pkg::CFG_INIT]; // R7 R8
        st_next.dbg_pin = st_reg.dbg; // R9 R10
        st_next.irq = |(st_reg.evt & st_reg.mask); // R12
        st_next.path = st_reg.pctl[2:0]; // R20 R24
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.cfg <= tpc_pkg::CONFIG_RST;
            st_reg.man <= tpc_pkg::MANUAL_RST;
            st_reg.mask <= tpc_pkg::MASK_RST[3:0];
            st_reg.vctl <= tpc_pkg::VCONN_RST[2:0]; // R24
            st_reg.pctl <= tpc_pkg::PATH_RST[4:0]; // R24
            st_reg.conn <= tpc_pkg::ST_UNATT;
            st_reg.rd_en <= 2'b11;
            st_reg.flip_pin <= 1'b1; // R8
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus_rdata = st_reg.rdata;
    assign cc_rp_en = st_reg.rp_en;
    assign cc_rd_en = st_reg.rd_en;
    assign rp_level_out = st_reg.cfg[2:1]; // R4
    assign vconn_to_cc = st_reg.vc_to;
    assign fwd_limit_out = st_reg.vctl[2:1]; // R15
    assign plug_flip_out = st_reg.flip_pin;
    assign debug_accessory_out = st_reg.dbg_pin;
    assign irq_n_oe = st_reg.irq;
    assign source_path_enable = st_reg.path[0];
    assign power_path_a_enable = st_reg.path[1];
    assign power_path_b_enable = st_reg.path[2];
endmodule

// file: tpc_port_properties.sv
// Purpose: port-level properties of the type-c port control block
// Assumes: bound to tpc_port_ctrl, single clock domain
// Notes: register writes are checked at the outputs two edges after the write edge
`timescale 1ns/1ps
module tpc_port_properties (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire tpc_pkg::tpc_bus_s bus_in,
    input wire logic [7:0] bus_rdata,
    input wire logic cable_power_in,
    input wire logic forward_overcurrent_guard,
    input wire logic reverse_current_guard,
    input wire logic [1:0] cc_rp_en,
    input wire logic [1:0] cc_rd_en,
    input wire logic [1:0] rp_level_out,
    input wire logic [1:0] vconn_to_cc,
    input wire logic [1:0] fwd_limit_out,
    input wire logic plug_flip_out,
    input wire logic debug_accessory_out,
    input wire logic source_path_enable,
    input wire logic power_path_a_enable,
    input wire logic power_path_b_enable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    AST_TERM: assert property (cc_rp_en inside {2'b00, 2'b11} && cc_rd_en == ~cc_rp_en)
        else $error("terminations do not match one role");
    AST_RST_OFF: assert property ($past(sys_rst) |-> vconn_to_cc == 2'b00 &&
        !source_path_enable && !power_path_a_enable && !power_path_b_enable)
        else $error("power switch on right after reset");
    AST_RST_PINS: assert property ($past(sys_rst) |-> plug_flip_out && !debug_accessory_out)
        else $error("orientation or accessory pin wrong after reset");
    AST_FWD_TRIP: assert property ((forward_overcurrent_guard && cable_power_in) [*5]
        |-> vconn_to_cc == 2'b00) else $error("forward trip left cable power on");
    AST_REV_TRIP: assert property ((reverse_current_guard && cable_power_in) [*5]
        |-> vconn_to_cc == 2'b00) else $error("reverse trip left cable power on");
    AST_VC_ONE: assert property (vconn_to_cc != 2'b11)
        else $error("cable power on both lines");
    AST_RDATA: assert property (!$past(bus_in.rd) |-> bus_rdata == 8'h00)
        else $error("read data outside its cycle");
    AST_PATH: assert property (bus_in.wr && bus_in.addr == tpc_pkg::ADDR_PATH |-> ##2
        {power_path_b_enable, power_path_a_enable, source_path_enable}
        == $past(bus_in.wdata[2:0], 2)) else $error("path enables differ from write");
    AST_RP_LVL: assert property (bus_in.wr && bus_in.addr == tpc_pkg::ADDR_CONFIG |-> ##2
        rp_level_out == $past(bus_in.wdata[2:1], 2)) else $error("advertised level wrong");
    AST_LIMIT: assert property (bus_in.wr && bus_in.addr == tpc_pkg::ADDR_VCONN |-> ##2
        fwd_limit_out == $past(bus_in.wdata[2:1], 2)) else $error("trip level wrong");
endmodule
bind tpc_port_ctrl tpc_port_properties i_tpc_port_properties (.clk_sys, .sys_rst, .bus_in,
    .bus_rdata, .cable_power_in, .forward_overcurrent_guard, .reverse_current_guard,
    .cc_rp_en, .cc_rd_en, .rp_level_out, .vconn_to_cc, .fwd_limit_out, .plug_flip_out,
    .debug_accessory_out, .source_path_enable, .power_path_a_enable, .power_path_b_enable);
